// [core/cmhp_chan.v]
// Per-channel setting store, latch snapshot and status byte
`timescale 1ns/1ps
`include "cmhp_defs.vh"
module cmhp_chan (
    input wire i_clk,
    input wire i_arst_n,
    input wire i_ce,
    input wire i_wr_init,
    input wire i_wr_mode,
    input wire i_wr_zclr,
    input wire i_wr_cmp,
    input wire i_wr_filt,
    input wire [1:0] i_byte_idx,
    input wire [7:0] i_wdata,
    input wire i_latch,
    input wire [23:0] i_count,
    input wire i_count_down,
    input wire i_abnormal,
    input wire i_ph_a,
    input wire i_ph_b,
    input wire i_ph_z,
    input wire i_gen_in,
    output wire [23:0] o_init,
    output wire o_init_load,
    output wire [7:0] o_mode,
    output wire [2:0] o_zclr,
    output wire [23:0] o_cmp,
    output wire [3:0] o_filt,
    output wire [23:0] o_snap,
    output wire [7:0] o_status
);
    reg [23:0] init_reg;
    reg init_load_reg;
    reg [7:0] mode_reg;
    reg [2:0] zclr_reg;
    reg [23:0] cmp_reg;
    reg [3:0] filt_reg;
    reg [23:0] snap_reg;
    wire compare_match_n;
    wire zview;

    always @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            init_reg <= 24'h000000;
            init_load_reg <= 1'b0;
            mode_reg <= 8'h00;
            zclr_reg <= 3'h0;
            cmp_reg <= 24'h000000;
            filt_reg <= 4'h0;
        end
        else if (i_ce)
        begin
            init_load_reg <= 1'b0;
            if (i_wr_init)
            begin
                init_reg[i_byte_idx*8 +: 8] <= i_wdata;
                init_load_reg <= (i_byte_idx == 2'd2);
            end
            if (i_wr_cmp)
                cmp_reg[i_byte_idx*8 +: 8] <= i_wdata;
            if (i_wr_mode)
                mode_reg <= i_wdata;
            if (i_wr_zclr)
                zclr_reg <= {i_wdata[2:1], 1'b0};
            if (i_wr_filt)
                filt_reg <= i_wdata[3:0];
        end
    end

    // Snapshot left unreset: undefined until first latch
    always @(posedge i_clk)
    begin
        if (i_ce && i_latch)
            snap_reg <= i_count;
    end

    assign compare_match_n = (i_count != cmp_reg);
    assign zview = i_ph_z ^ mode_reg[`CMHP_MODE_INDEX_POLARITY_SELECT];
    // Bit order AI Z A B 1 U/D EQ U
    assign o_status = {i_abnormal, zview, i_ph_a, i_ph_b, 1'b1,
                       i_count_down, compare_match_n, i_gen_in};
    assign o_init = init_reg;
    assign o_init_load = init_load_reg;
    assign o_mode = mode_reg;
    assign o_zclr = zclr_reg;
    assign o_cmp = cmp_reg;
    assign o_filt = filt_reg;
    assign o_snap = snap_reg;
endmodule

// [core/cmhp_defs.vh]
// Constants for the counter module host port
`ifndef CMHP_DEFS_VH
`define CMHP_DEFS_VH
// Port offsets
`define CMHP_OFS_INFO 5'h00
`define CMHP_OFS_PNUM 5'h01
`define CMHP_OFS_IRQ 5'h02
`define CMHP_OFS_CMD 5'h10
`define CMHP_OFS_DATA 5'h11
`define CMHP_COMMON_TOP 5'h0f
// Identification values (arbitrary)
`define CMHP_CATEGORY 4'h5
`define CMHP_REVISION 4'h1
`define CMHP_PRODUCT_NUM 8'h2a
// Commands
`define CMHP_C_INIT0 8'h00
`define CMHP_C_MODE0 8'h01
`define CMHP_C_ZCLR0 8'h02
`define CMHP_C_CMP0 8'h03
`define CMHP_C_FILT0 8'h04
`define CMHP_C_INIT1 8'h05
`define CMHP_C_MODE1 8'h06
`define CMHP_C_ZCLR1 8'h07
`define CMHP_C_CMP1 8'h08
`define CMHP_C_FILT1 8'h09
`define CMHP_C_LATCH 8'h14
`define CMHP_C_MASK 8'h15
`define CMHP_C_SENSE 8'h16
`define CMHP_C_TIMER 8'h17
`define CMHP_C_TSTART 8'h18
`define CMHP_C_ONESHOT 8'h19
// Reset values and constants
`define CMHP_MASK_RST 3'h7
`define CMHP_CMD_RST 8'hff
`define CMHP_CMD_PORT_RD 8'hff
`define CMHP_IDLE_RD 8'h00
`define CMHP_MODE_INDEX_POLARITY_SELECT 5
`endif

// [core/cmhp_sync.v]
// Two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module cmhp_sync #(
    parameter W = 8
) (
    input wire i_clk,
    input wire i_arst_n,
    input wire i_ce,
    input wire [W-1:0] i_d,
    output wire [W-1:0] o_q
);
    reg [W-1:0] s1_reg;
    reg [W-1:0] s2_reg;
    always @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            s1_reg <= {W{1'b0}};
            s2_reg <= {W{1'b0}};
        end
        else if (i_ce)
        begin
            s1_reg <= i_d;
            s2_reg <= s1_reg;
        end
    end
    assign o_q = s2_reg;
endmodule

// [core/cmhp_top.v]
// Host port of the two-channel counter module
// What this block does
// - Offsets 0 to F hold the common family layout; counter ports sit above.
// - Offset 0 reads category code high nibble, revision low nibble.
// - Offset 1 reads a fixed eight-bit product number.
// - Offset 2 bit 7 reads one when the interrupt source is enabled.
// - Offset 2 bit 6 is one whenever any level bit is one.
// - Offset 2 low bits show selected level; bits 5 to 3 read zero.
// - Write to offset 2 stores enable bit 7 and level bits 2 to 0.
// - Command port write selects register reached through the data port.
// - Per-channel write commands 00-04 and 05-09 load the settings.
// - Z clear command keeps bits 2 and 1, bit 0 zero.
// - Command 17 loads timer value; command 18 bit 0 starts timer.
// - Command 19 loads the one-shot pulse width.
// - Count read returns low, middle, high bytes of latched count.
// - Readback snapshot is undefined before the first latch.
// - Status byte: AI, Z, A, B, one, direction, match_n, generic input.
// - Abnormal flag sets on simultaneous change of both count inputs.
// - Z status bit follows input, inverted under negative logic.
// - Phase A and B status bits show levels without inversion.
// - Direction bit reads zero counting up, one counting down.
// - Match bit reads zero on equal, one when different.
// - Mask command holds timer and channel bits, all set after reset.
// - Sense bits stay set until cleared by the sense reset command.
// - Generic input unfiltered; phase bits come from the filtered path.
`timescale 1ns/1ps
`include "cmhp_defs.vh"
module cmhp_top (
    input wire I_CLK_SYS,
    input wire I_ARST_N,
    input wire I_CE,
    input wire [4:0] I_ADDR,
    input wire I_RD,
    input wire I_WR,
    input wire [7:0] I_WDATA,
    output wire [7:0] O_RDATA,
    input wire [23:0] I_COUNT0,
    input wire [23:0] I_COUNT1,
    input wire I_DOWN0,
    input wire I_DOWN1,
    input wire [1:0] I_CHG_A,
    input wire [1:0] I_CHG_B,
    input wire [1:0] I_FILT_A,
    input wire [1:0] I_FILT_B,
    input wire [1:0] I_FILT_Z,
    input wire [1:0] I_GEN_IN,
    input wire [1:0] I_MATCH_EV,
    input wire I_TIMER_EV,
    output wire [23:0] O_INIT0,
    output wire [23:0] O_INIT1,
    output wire O_INIT_LOAD0,
    output wire O_INIT_LOAD1,
    output wire [7:0] O_MODE0,
    output wire [7:0] O_MODE1,
    output wire [2:0] O_ZCLR0,
    output wire [2:0] O_ZCLR1,
    output wire [23:0] O_CMP0,
    output wire [23:0] O_CMP1,
    output wire [3:0] O_FILT0,
    output wire [3:0] O_FILT1,
    output wire [7:0] O_TIMER_VAL,
    output wire O_TIMER_START,
    output wire [7:0] O_ONESHOT_W,
    output wire [2:0] O_SENSE,
    output wire [2:0] O_MASK,
    output wire O_IRQ_REQ,
    output wire O_IRQ_EN,
    output wire [2:0] O_IRQ_LEVEL
);
    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    // Generic input and phase changes arrive from the pins
    wire [1:0] gen_s;
    wire [1:0] chg_a_s;
    wire [1:0] chg_b_s;
    cmhp_sync #(.W(6)) u_sync (
        .i_clk(I_CLK_SYS),
        .i_arst_n(I_ARST_N),
        .i_ce(I_CE),
        .i_d({I_GEN_IN, I_CHG_A, I_CHG_B}),
        .o_q({gen_s, chg_a_s, chg_b_s})
    );

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    wire wr_irq;
    wire wr_cmd;
    wire wr_data;
    wire rd_data;
    assign wr_irq = I_CE & I_WR & (I_ADDR == `CMHP_OFS_IRQ);
    assign wr_cmd = I_CE & I_WR & (I_ADDR == `CMHP_OFS_CMD);
    assign wr_data = I_CE & I_WR & (I_ADDR == `CMHP_OFS_DATA);
    assign rd_data = I_CE & I_RD & (I_ADDR == `CMHP_OFS_DATA);

    reg [7:0] cmd_reg;
    reg [1:0] byte_reg;
    reg irq_en_reg;
    reg [2:0] irq_lvl_reg;
    reg [2:0] mask_reg;
    reg [2:0] sense_reg;
    reg [1:0] ai_reg;
    reg [7:0] timer_reg;
    reg timer_start_reg;
    reg [7:0] oneshot_reg;
    reg [7:0] rdata_reg;
    reg [7:0] rdata_next;
    reg [2:0] sense_next;

    // ****************************************************************
    // Command and byte sequencer
    // ****************************************************************
    // A data access advances the byte pointer; wraps after high byte
    always @(posedge I_CLK_SYS or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            cmd_reg <= `CMHP_CMD_RST;
            byte_reg <= 2'd0;
        end
        else if (I_CE)
        begin
            if (wr_cmd)
            begin
                cmd_reg <= I_WDATA;
                byte_reg <= 2'd0;
            end
            else if (wr_data || rd_data)
                byte_reg <= (byte_reg == 2'd2) ? 2'd0 : byte_reg + 2'd1;
        end
    end

    // ****************************************************************
    // Command strobes
    // ****************************************************************
    // Data-port writes under any other command are dropped
    wire wr_mask;
    wire wr_sense;
    wire wr_timer;
    wire wr_tstart;
    wire wr_oneshot;
    wire [2:0] wr_src_bits;
    wire [7:0] mask_view;
    wire [7:0] sense_view;
    wire [1:0] ai_set;
    assign wr_mask = wr_data & (cmd_reg == `CMHP_C_MASK);
    assign wr_sense = wr_data & (cmd_reg == `CMHP_C_SENSE);
    assign wr_timer = wr_data & (cmd_reg == `CMHP_C_TIMER);
    assign wr_tstart = wr_data & (cmd_reg == `CMHP_C_TSTART);
    assign wr_oneshot = wr_data & (cmd_reg == `CMHP_C_ONESHOT);
    // Mask and sense share one layout: timer at bit 4, channels low
    assign wr_src_bits = {I_WDATA[4], I_WDATA[1:0]};
    assign mask_view = {3'b000, mask_reg[2], 2'b00, mask_reg[1:0]};
    assign sense_view = {3'b000, sense_reg[2], 2'b00, sense_reg[1:0]};
    // Both inputs changing together flags abnormal input
    assign ai_set = chg_a_s & chg_b_s;

    // ****************************************************************
    // Channel strobes
    // ****************************************************************
    wire [1:0] latch_pulse;
    wire [7:0] status0;
    wire [7:0] status1;
    wire [23:0] snap0;
    wire [23:0] snap1;
    wire wr_latch;
    assign wr_latch = wr_data & (cmd_reg == `CMHP_C_LATCH);
    // Bit 0 latch_first_channel, bit 1 latch_second_channel
    assign latch_pulse = wr_latch ? I_WDATA[1:0] : 2'b00;

    cmhp_chan u_ch0 (
        .i_clk(I_CLK_SYS),
        .i_arst_n(I_ARST_N),
        .i_ce(I_CE),
        .i_wr_init(wr_data & (cmd_reg == `CMHP_C_INIT0)),
        .i_wr_mode(wr_data & (cmd_reg == `CMHP_C_MODE0)),
        .i_wr_zclr(wr_data & (cmd_reg == `CMHP_C_ZCLR0)),
        .i_wr_cmp(wr_data & (cmd_reg == `CMHP_C_CMP0)),
        .i_wr_filt(wr_data & (cmd_reg == `CMHP_C_FILT0)),
        .i_byte_idx(byte_reg),
        .i_wdata(I_WDATA),
        .i_latch(latch_pulse[0]),
        .i_count(I_COUNT0),
        .i_count_down(I_DOWN0),
        .i_abnormal(ai_reg[0]),
        .i_ph_a(I_FILT_A[0]),
        .i_ph_b(I_FILT_B[0]),
        .i_ph_z(I_FILT_Z[0]),
        .i_gen_in(gen_s[0]),
        .o_init(O_INIT0),
        .o_init_load(O_INIT_LOAD0),
        .o_mode(O_MODE0),
        .o_zclr(O_ZCLR0),
        .o_cmp(O_CMP0),
        .o_filt(O_FILT0),
        .o_snap(snap0),
        .o_status(status0)
    );

    cmhp_chan u_ch1 (
        .i_clk(I_CLK_SYS),
        .i_arst_n(I_ARST_N),
        .i_ce(I_CE),
        .i_wr_init(wr_data & (cmd_reg == `CMHP_C_INIT1)),
        .i_wr_mode(wr_data & (cmd_reg == `CMHP_C_MODE1)),
        .i_wr_zclr(wr_data & (cmd_reg == `CMHP_C_ZCLR1)),
        .i_wr_cmp(wr_data & (cmd_reg == `CMHP_C_CMP1)),
        .i_wr_filt(wr_data & (cmd_reg == `CMHP_C_FILT1)),
        .i_byte_idx(byte_reg),
        .i_wdata(I_WDATA),
        .i_latch(latch_pulse[1]),
        .i_count(I_COUNT1),
        .i_count_down(I_DOWN1),
        .i_abnormal(ai_reg[1]),
        .i_ph_a(I_FILT_A[1]),
        .i_ph_b(I_FILT_B[1]),
        .i_ph_z(I_FILT_Z[1]),
        .i_gen_in(gen_s[1]),
        .o_init(O_INIT1),
        .o_init_load(O_INIT_LOAD1),
        .o_mode(O_MODE1),
        .o_zclr(O_ZCLR1),
        .o_cmp(O_CMP1),
        .o_filt(O_FILT1),
        .o_snap(snap1),
        .o_status(status1)
    );

    // ****************************************************************
    // Interrupt, mask, sense, timer settings
    // ****************************************************************
    // Sense events win over a same-cycle clear so no event is lost
    always @*
    begin
        sense_next = sense_reg;
        if (wr_sense)
            sense_next = sense_next & ~wr_src_bits;
        sense_next = sense_next | {I_TIMER_EV, I_MATCH_EV};
    end

    always @(posedge I_CLK_SYS or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            irq_en_reg <= 1'b0;
            irq_lvl_reg <= 3'h0;
            mask_reg <= `CMHP_MASK_RST;
            sense_reg <= 3'h0;
            ai_reg <= 2'b00;
            timer_reg <= 8'h00;
            timer_start_reg <= 1'b0;
            oneshot_reg <= 8'h00;
        end
        else if (I_CE)
        begin
            timer_start_reg <= 1'b0;
            sense_reg <= sense_next;
            ai_reg <= ai_reg | ai_set;
            if (wr_irq)
            begin
                irq_en_reg <= I_WDATA[7];
                irq_lvl_reg <= I_WDATA[2:0];
            end
            if (wr_mask)
                mask_reg <= wr_src_bits;
            if (wr_timer)
                timer_reg <= I_WDATA;
            if (wr_tstart)
                timer_start_reg <= I_WDATA[0];
            if (wr_oneshot)
                oneshot_reg <= I_WDATA;
        end
    end

    // ****************************************************************
    // Read mux
    // ****************************************************************
    // Registered data, valid one edge after the read strobe
    always @*
    begin
        rdata_next = `CMHP_IDLE_RD;
        if (I_ADDR <= `CMHP_COMMON_TOP)
        begin
            case (I_ADDR)
                `CMHP_OFS_INFO:
                    rdata_next = {`CMHP_CATEGORY, `CMHP_REVISION};
                `CMHP_OFS_PNUM:
                    rdata_next = `CMHP_PRODUCT_NUM;
                `CMHP_OFS_IRQ:
                    rdata_next = {irq_en_reg, |irq_lvl_reg, 3'b000,
                                  irq_lvl_reg};
                default:
                    rdata_next = `CMHP_IDLE_RD;
            endcase
        end
        else if (I_ADDR == `CMHP_OFS_CMD)
            rdata_next = `CMHP_CMD_PORT_RD;
        else if (I_ADDR == `CMHP_OFS_DATA)
        begin
            // Any data-port read also steps the byte pointer
            case (cmd_reg)
                `CMHP_C_INIT0:
                    rdata_next = snap0[byte_reg*8 +: 8];
                `CMHP_C_INIT1:
                    rdata_next = snap1[byte_reg*8 +: 8];
                `CMHP_C_MODE0:
                    rdata_next = status0;
                `CMHP_C_MODE1:
                    rdata_next = status1;
                `CMHP_C_MASK:
                    rdata_next = mask_view;
                `CMHP_C_SENSE:
                    rdata_next = sense_view;
                default:
                    rdata_next = `CMHP_IDLE_RD;
            endcase
        end
    end

    always @(posedge I_CLK_SYS or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            rdata_reg <= `CMHP_IDLE_RD;
        else if (I_CE && I_RD)
            rdata_reg <= rdata_next;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign O_RDATA = rdata_reg;
    assign O_TIMER_VAL = timer_reg;
    assign O_TIMER_START = timer_start_reg;
    assign O_ONESHOT_W = oneshot_reg;
    assign O_SENSE = sense_reg;
    assign O_MASK = mask_reg;
    // Request only for unmasked sense; held until sense reset
    assign O_IRQ_REQ = irq_en_reg & |(sense_reg & ~mask_reg);
    assign O_IRQ_EN = irq_en_reg;
    assign O_IRQ_LEVEL = irq_lvl_reg;
endmodule

// [verif/cmhp_bench.sv]
// Self-checking bench for the counter module host port
`timescale 1ns/1ps
`include "cmhp_defs.vh"
module cmhp_bench;
reg clk = 1'h0;
reg arst_n = 1'h0;
reg [23:0] cnt0 = 24'h0, cnt1 = 24'h0;
reg dn0 = 1'h0, dn1 = 1'h0, tev = 1'h0;
reg [1:0] chg_a = 2'h0, chg_b = 2'h0, fa = 2'h0, fb = 2'h0;
reg [1:0] fz = 2'h0, gen = 2'h0, mev = 2'h0;
wire ce, rd, wr, ld0, ld1, tst, req, en;
wire [4:0] addr;
wire [7:0] wdata, rdata, mode0, mode1, tval, osw;
wire [23:0] init0, init1, cmp0, cmp1;
wire [2:0] zc0, zc1, sense, mask, lvl;
wire [3:0] flt0, flt1;
integer fails = 0, total_checks = 0, i;
reg [7:0] b, c;
always #12.5 clk = ~clk;
cmhp_host_model host (.i_clk(clk), .i_rdata(rdata), .o_ce(ce),
    .o_addr(addr), .o_rd(rd), .o_wr(wr), .o_wdata(wdata));
cmhp_top DUT (
    .I_CLK_SYS(clk), .I_ARST_N(arst_n), .I_CE(ce), .I_ADDR(addr),
    .I_RD(rd), .I_WR(wr), .I_WDATA(wdata), .O_RDATA(rdata),
    .I_COUNT0(cnt0), .I_COUNT1(cnt1), .I_DOWN0(dn0), .I_DOWN1(dn1),
    .I_CHG_A(chg_a), .I_CHG_B(chg_b), .I_FILT_A(fa), .I_FILT_B(fb),
    .I_FILT_Z(fz), .I_GEN_IN(gen), .I_MATCH_EV(mev), .I_TIMER_EV(tev),
    .O_INIT0(init0), .O_INIT1(init1), .O_INIT_LOAD0(ld0),
    .O_INIT_LOAD1(ld1), .O_MODE0(mode0), .O_MODE1(mode1),
    .O_ZCLR0(zc0), .O_ZCLR1(zc1), .O_CMP0(cmp0), .O_CMP1(cmp1),
    .O_FILT0(flt0), .O_FILT1(flt1), .O_TIMER_VAL(tval),
    .O_TIMER_START(tst), .O_ONESHOT_W(osw), .O_SENSE(sense),
    .O_MASK(mask), .O_IRQ_REQ(req), .O_IRQ_EN(en), .O_IRQ_LEVEL(lvl)
);
// ****************
// Checking and bus helpers
// ****************
task chk8(input [7:0] got, input [7:0] exp);
begin
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
        fails = fails + 1;
        $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
    end
end
endtask
task chk24(input [23:0] got, input [23:0] exp);
begin
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
        fails = fails + 1;
        $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
end
endtask
task rdchk(input [4:0] a, input [7:0] e);
begin
    host.rd(a, b);
    chk8(b, e);
end
endtask
task cmdrd(input [7:0] cm, input [7:0] e);
begin
    host.wr(5'h10, cm);
    rdchk(5'h11, e);
end
endtask
// Multi-byte values go low byte first
task w24(input [7:0] cm, input [23:0] v);
begin
    host.wr(5'h10, cm);
    host.wr(5'h11, v[7:0]);
    host.wr(5'h11, v[15:8]);
    host.wr(5'h11, v[23:16]);
end
endtask
task close_out;
begin
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
end
endtask
initial
begin
    #100000;
    fails = fails + 1;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out;
end
initial
begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    arst_n = 1'h1;
    chk8({5'h0, mask}, 8'h07);
    chk8({4'h0, sense, en}, 8'h00);
    rdchk(5'h00, {`CMHP_CATEGORY, `CMHP_REVISION});
    rdchk(5'h01, `CMHP_PRODUCT_NUM);
    rdchk(5'h0f, `CMHP_IDLE_RD);
    host.wr(5'h02, 8'h81);
    rdchk(5'h02, 8'hc1);
    host.wr(5'h02, 8'h04);
    rdchk(5'h02, 8'h44);
    for (i = 0; i < 2; i = i + 1)
    begin
        c = i ? 8'h05 : 8'h00;
        w24(c, 24'h123456 ^ i);
        chk24(i ? init1 : init0, 24'h123456 ^ i);
        chk8({7'h0, i ? ld1 : ld0}, 8'h01);
        host.cmd_wr(c + 8'h01, i ? 8'ha0 : 8'h80);
        chk8(i ? mode1 : mode0, i ? 8'ha0 : 8'h80);
        host.cmd_wr(c + 8'h02, 8'h07);
        chk8({5'h0, i ? zc1 : zc0}, 8'h06);
        w24(c + 8'h03, i ? 24'h000001 : 24'ha1b2c3);
        chk24(i ? cmp1 : cmp0, i ? 24'h000001 : 24'ha1b2c3);
        host.cmd_wr(c + 8'h04, 8'hf9 - i);
        chk8({4'h0, i ? flt1 : flt0}, 8'h09 - i);
    end
    host.cmd_wr(8'h17, 8'h5a);
    chk8(tval, 8'h5a);
    host.cmd_wr(8'h18, 8'h01);
    chk8({7'h0, tst}, 8'h01);
    host.cmd_wr(8'h19, 8'h3c);
    chk8(osw, 8'h3c);
    cnt0 = 24'ha1b2c3;
    cnt1 = 24'h000002;
    host.cmd_wr(8'h14, 8'h03);
    cnt1 = 24'h000000;
    cmdrd(8'h00, 8'hc3);
    rdchk(5'h10, `CMHP_CMD_PORT_RD);
    rdchk(5'h11, 8'hb2);
    rdchk(5'h11, 8'ha1);
    cmdrd(8'h05, 8'h02);
    cmdrd(8'h05, 8'h02);
    rdchk(5'h11, 8'h00);
    cmdrd(8'h17, `CMHP_IDLE_RD);
    fa = 2'h1;
    fb = 2'h2;
    fz = 2'h3;
    dn0 = 1'h1;
    gen = 2'h1;
    chg_a = 2'h2;
    chg_b = 2'h2;
    @(negedge clk);
    chg_a = 2'h0;
    chg_b = 2'h0;
    // Pin inputs cross two synchroniser stages
    repeat (4) @(negedge clk);
    cmdrd(8'h01, 8'h6d);
    cmdrd(8'h06, 8'h9a);
    cmdrd(8'h15, 8'h13);
    host.cmd_wr(8'h15, 8'h00);
    cmdrd(8'h15, 8'h00);
    host.wr(5'h02, 8'h81);
    mev = 2'h2;
    @(negedge clk);
    mev = 2'h0;
    chk8({4'h0, sense, req}, 8'h05);
    tev = 1'h1;
    @(negedge clk);
    tev = 1'h0;
    cmdrd(8'h16, 8'h12);
    host.cmd_wr(8'h16, 8'h10);
    cmdrd(8'h16, 8'h02);
    host.cmd_wr(8'h16, 8'h02);
    chk8({4'h0, sense, req}, 8'h00);
    host.cmd_wr(8'h15, 8'h01);
    mev = 2'h1;
    @(negedge clk);
    mev = 2'h0;
    chk8({4'h0, sense, req}, 8'h02);
    // Clock enable low: the write below must not be taken
    host.o_ce = 1'h0;
    host.wr(5'h02, 8'h00);
    host.o_ce = 1'h1;
    chk8({en, 4'h0, lvl}, 8'h81);
    close_out;
end
endmodule

// [verif/cmhp_host_model.sv]
// Controller processor model on the byte-wide port bus
`timescale 1ns/1ps
module cmhp_host_model (
    input wire i_clk,
    input wire [7:0] i_rdata,
    output reg o_ce,
    output reg [4:0] o_addr,
    output reg o_rd,
    output reg o_wr,
    output reg [7:0] o_wdata
);
initial
begin
    o_ce = 1'h1;
    o_addr = 5'h1f;
    o_rd = 1'h0;
    o_wr = 1'h0;
    o_wdata = 8'h00;
end
// Released lines show the inverse, never a stale value
task wr(input [4:0] a, input [7:0] d);
begin
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'h1;
    @(negedge i_clk);
    o_wr = 1'h0;
    o_addr = ~a;
    o_wdata = ~d;
end
endtask
task rd(input [4:0] a, output [7:0] d);
begin
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'h1;
    @(negedge i_clk);
    o_rd = 1'h0;
    o_addr = ~a;
    d = i_rdata;
end
endtask
// Command is written afresh for every sequence
task cmd_wr(input [7:0] c, input [7:0] d);
begin
    wr(5'h10, c);
    wr(5'h11, d);
end
endtask
endmodule

// [verif/cmhp_properties.sv]
// Port-level assertions for the counter module host port
`timescale 1ns/1ps
`include "cmhp_defs.vh"
module cmhp_properties (
    input wire I_CLK_SYS,
    input wire I_ARST_N,
    input wire I_CE,
    input wire [4:0] I_ADDR,
    input wire I_RD,
    input wire I_WR,
    input wire [7:0] I_WDATA,
    input wire [7:0] O_RDATA,
    input wire I_TIMER_EV,
    input wire [23:0] O_INIT0,
    input wire O_INIT_LOAD0,
    input wire [2:0] O_ZCLR0,
    input wire O_TIMER_START,
    input wire [2:0] O_SENSE,
    input wire [2:0] O_MASK,
    input wire O_IRQ_REQ,
    input wire O_IRQ_EN,
    input wire [2:0] O_IRQ_LEVEL
);
// ****************
// Command shadow
// ****************
reg [7:0] cmd_reg;
wire rd_ok = I_CE && I_RD;
wire wr_ok = I_CE && I_WR;
wire wr_cmd = wr_ok && I_ADDR == `CMHP_OFS_CMD;
wire wr_dat = wr_ok && I_ADDR == `CMHP_OFS_DATA;
always @(posedge I_CLK_SYS or negedge I_ARST_N)
begin
    if (!I_ARST_N)
        cmd_reg <= `CMHP_CMD_RST;
    else if (wr_cmd)
        cmd_reg <= I_WDATA;
end
default clocking dc @(posedge I_CLK_SYS);
endclocking
default disable iff (!I_ARST_N);
sequence init_cmd_s;
    wr_cmd && I_WDATA == `CMHP_C_INIT0;
endsequence
// Host model spaces bus cycles two clocks apart
sequence three_bytes_s;
    wr_dat ##2 wr_dat ##2 wr_dat;
endsequence
info_read_a:
assert property (rd_ok && I_ADDR == `CMHP_OFS_INFO |=>
    O_RDATA == {`CMHP_CATEGORY, `CMHP_REVISION}) else $error("info bad");
pnum_read_a:
assert property (rd_ok && I_ADDR == `CMHP_OFS_PNUM |=>
    O_RDATA == `CMHP_PRODUCT_NUM) else $error("product number bad");
irq_view_a:
assert property (rd_ok && I_ADDR == `CMHP_OFS_IRQ |=> O_RDATA ==
    {$past(O_IRQ_EN), |$past(O_IRQ_LEVEL), 3'h0, $past(O_IRQ_LEVEL)})
    else $error("interrupt view bad");
irq_store_a:
assert property (wr_ok && I_ADDR == `CMHP_OFS_IRQ |=>
    O_IRQ_EN == $past(I_WDATA[7]) && O_IRQ_LEVEL == $past(I_WDATA[2:0]))
    else $error("interrupt setting not stored");
init_load_a:
assert property (init_cmd_s ##2 three_bytes_s |=> O_INIT_LOAD0 &&
    O_INIT0 == {$past(I_WDATA, 1), $past(I_WDATA, 3), $past(I_WDATA, 5)})
    else $error("initial count load bad");
zclr_store_a:
assert property (wr_dat && cmd_reg == `CMHP_C_ZCLR0 |=>
    O_ZCLR0 == {$past(I_WDATA[2:1]), 1'h0}) else $error("zclear bad");
timer_start_a:
assert property (wr_dat && cmd_reg == `CMHP_C_TSTART && I_WDATA[0] |=>
    O_TIMER_START ##1 !O_TIMER_START) else $error("timer start bad");
irq_req_a:
assert property (O_IRQ_REQ == (O_IRQ_EN && |(O_SENSE & ~O_MASK)))
    else $error("request level bad");
timer_sense_a:
assert property (I_CE && I_TIMER_EV |=> O_SENSE[2])
    else $error("timer sense not set");
sense_hold_a:
assert property (O_SENSE[0] && !(wr_dat && cmd_reg == `CMHP_C_SENSE &&
    I_WDATA[0]) |=> O_SENSE[0]) else $error("channel sense dropped");
sense_clear_a:
assert property (wr_dat && cmd_reg == `CMHP_C_SENSE && I_WDATA[4] &&
    !I_TIMER_EV |=> !O_SENSE[2]) else $error("timer sense not cleared");
endmodule
bind cmhp_top cmhp_properties chk (
    .I_CLK_SYS(I_CLK_SYS), .I_ARST_N(I_ARST_N), .I_CE(I_CE),
    .I_ADDR(I_ADDR), .I_RD(I_RD), .I_WR(I_WR), .I_WDATA(I_WDATA),
    .O_RDATA(O_RDATA), .I_TIMER_EV(I_TIMER_EV), .O_INIT0(O_INIT0),
    .O_INIT_LOAD0(O_INIT_LOAD0), .O_ZCLR0(O_ZCLR0),
    .O_TIMER_START(O_TIMER_START), .O_SENSE(O_SENSE), .O_MASK(O_MASK),
    .O_IRQ_REQ(O_IRQ_REQ), .O_IRQ_EN(O_IRQ_EN), .O_IRQ_LEVEL(O_IRQ_LEVEL)
);
